// ==== sfpi_pkg.sv ====
// Shared constants, types and helpers for the serial flash pin interface
package sfpi_pkg;

    // ----------------------------------------
    // Constants
    // ----------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int ADDR_W = 24;
    localparam int BLOCK_SHIFT = 16;
    localparam int CNT_W = 4;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] PROTECT_NONE = 3'h0;
    localparam logic [2:0] PROTECT_ALL = 3'h7;
    localparam logic [8:0] NUM_BLOCKS = 9'h100;
    localparam logic [8:0] ONE_BLOCK = 9'h001;
    localparam logic [3:0] OE_NONE = 4'hF;
    localparam logic [3:0] OE_SINGLE = 4'hD;
    localparam logic [3:0] OE_DUAL = 4'hC;
    localparam logic [3:0] OE_QUAD = 4'h0;
    localparam logic [CNT_W-1:0] STEP_SINGLE = 4'h1;
    localparam logic [CNT_W-1:0] STEP_DUAL = 4'h2;
    localparam logic [CNT_W-1:0] STEP_QUAD = 4'h4;
    localparam logic [CNT_W-1:0] CNT_BYTE = 4'h8;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef enum logic [1:0] {
        LANE_SINGLE = 2'h0,
        LANE_DUAL = 2'h1,
        LANE_QUAD = 2'h3
    } sfpi_lane_t;

    typedef enum logic [1:0] {
        ST_POWERUP = 2'h0,
        ST_DESEL = 2'h1,
        ST_ACTIVE = 2'h3,
        ST_PAUSED = 2'h2
    } sfpi_state_t;

    typedef struct packed {
        logic sclk;
        logic cs_n;
        logic [3:0] io;
    } sfpi_pins_in_t;

    typedef struct packed {
        logic [3:0] io;
        logic [3:0] io_oe_n;
    } sfpi_pins_out_t;

    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } sfpi_wreq_t;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Quad needs the extra lanes released from control use
    function automatic sfpi_lane_t sfpi_eff_mode(input sfpi_lane_t m, input logic four_lane);
        if (m == LANE_QUAD && !four_lane) begin
            return LANE_SINGLE;
        end
        return m;
    endfunction

    function automatic logic [CNT_W-1:0] sfpi_step(input sfpi_lane_t m);
        unique case (m)
            LANE_DUAL: return STEP_DUAL;
            LANE_QUAD: return STEP_QUAD;
            default: return STEP_SINGLE;
        endcase
    endfunction

    // Top part of the array, growing by powers of two
    function automatic logic sfpi_in_area(input logic [ADDR_W-1:0] addr, input logic [2:0] bp);
        logic [8:0] first;
        first = NUM_BLOCKS - (ONE_BLOCK << (bp - 3'h1));
        if (bp == PROTECT_NONE) begin
            return 1'b0;
        end
        if (bp == PROTECT_ALL) begin
            return 1'b1;
        end
        return {1'b0, addr[ADDR_W-1:BLOCK_SHIFT]} >= first;
    endfunction

endpackage

// ==== sfpi_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module sfpi_fifo
    import sfpi_pkg::*;
#(
    parameter int WIDTH = BYTE_BITS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [AW:0] count, next_count;
    logic push, pop;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        in_ready_o = (count != DEPTH[AW:0]);
        out_valid_o = (count != '0);
        out_data_o = mem[rd_ptr];
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
        next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
        next_count = count;
        if (push && !pop) begin
            next_count = (AW+1)'(count + 1'b1);
        end else if (pop && !push) begin
            next_count = (AW+1)'(count - 1'b1);
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule

// ==== sfpi_flash_pins.sv ====
// Device-side pin interface of a serial flash memory
`timescale 1ns/100ps
module sfpi_flash_pins
    import sfpi_pkg::*;
#(
    parameter int RX_DEPTH = FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire sfpi_pins_in_t pins_i,
    output sfpi_pins_out_t pins_o,
    input wire sfpi_lane_t lane_mode_i,
    input wire logic drive_out_i,
    input wire logic four_lane_enable_i,
    input wire logic [2:0] protect_area_bits_i,
    input wire logic op_busy_i,
    input wire sfpi_wreq_t wreq_i,
    output logic write_allowed_o,
    output logic write_ack_o,
    output logic [BYTE_BITS-1:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic rx_overrun_o,
    input wire logic [BYTE_BITS-1:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic selected_o,
    output logic standby_o
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    sfpi_pins_in_t sync1, sync2, prev;

    always_ff @(posedge clk_i) begin
        sync1 <= pins_i;
        sync2 <= sync1;
        prev <= sync2;
    end

    logic sclk_rise, sclk_fall, cs_fall, pause_n, protect_on;
    sfpi_lane_t mode;
    logic [CNT_W-1:0] step;

    always_comb begin
        sclk_rise = sync2.sclk && !prev.sclk;
        sclk_fall = !sync2.sclk && prev.sclk;
        cs_fall = prev.cs_n && !sync2.cs_n;
        pause_n = four_lane_enable_i || sync2.io[3];
        protect_on = !four_lane_enable_i && !sync2.io[2];
        mode = sfpi_eff_mode(lane_mode_i, four_lane_enable_i);
        step = sfpi_step(mode);
    end

    // ----------------------------------------
    // Select and pause state
    // ----------------------------------------
    sfpi_state_t state, next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_POWERUP: if (cs_fall) next_state = ST_ACTIVE;
            ST_DESEL: if (!sync2.cs_n) next_state = ST_ACTIVE;
            ST_ACTIVE: begin
                if (sync2.cs_n) begin
                    next_state = ST_DESEL;
                end else if (!pause_n) begin
                    next_state = ST_PAUSED;
                end
            end
            ST_PAUSED: begin
                if (sync2.cs_n) begin
                    next_state = ST_DESEL;
                end else if (pause_n) begin
                    next_state = ST_ACTIVE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state <= ST_POWERUP;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // Shifters and pins
    // ----------------------------------------
    logic [CNT_W-1:0] cnt, next_cnt, cnt_plus;
    logic [BYTE_BITS-1:0] shin, next_shin, shout, next_shout, cur;
    sfpi_pins_out_t next_pins;
    logic overrun, next_overrun, rx_push, rx_in_ready;
    logic [BYTE_BITS-1:0] rx_byte;
    logic live;

    always_comb begin
        live = (state == ST_ACTIVE);
        cnt_plus = CNT_W'(cnt + step);
        next_cnt = cnt;
        next_shin = shin;
        next_shout = shout;
        next_overrun = overrun;
        next_pins = pins_o;
        rx_push = 1'b0;
        rx_byte = shin;
        tx_ready_o = 1'b0;
        cur = shout;
        if (state != ST_ACTIVE && state != ST_PAUSED) begin
            next_cnt = CNT_ZERO;
            next_overrun = 1'b0;
        end
        if (live && !drive_out_i && sclk_rise) begin
            unique case (mode)
                LANE_DUAL: next_shin = {shin[BYTE_BITS-3:0], sync2.io[1:0]};
                LANE_QUAD: next_shin = {shin[BYTE_BITS-5:0], sync2.io[3:0]};
                default: next_shin = {shin[BYTE_BITS-2:0], sync2.io[0]};
            endcase
            rx_byte = next_shin;
            next_cnt = (cnt_plus == CNT_BYTE) ? CNT_ZERO : cnt_plus;
            if (cnt_plus == CNT_BYTE) begin
                rx_push = 1'b1;
                next_overrun = overrun || !rx_in_ready;
            end
        end
        if (live && drive_out_i && sclk_fall) begin
            if (cnt == CNT_ZERO) begin
                tx_ready_o = 1'b1;
                cur = tx_valid_i ? tx_data_i : '0;
            end
            unique case (mode)
                LANE_DUAL: next_pins.io[1:0] = cur[BYTE_BITS-1 -: 2];
                LANE_QUAD: next_pins.io = cur[BYTE_BITS-1 -: 4];
                default: next_pins.io[1] = cur[BYTE_BITS-1];
            endcase
            next_shout = cur << step;
            next_cnt = (cnt_plus == CNT_BYTE) ? CNT_ZERO : cnt_plus;
        end
        next_pins.io_oe_n = OE_NONE;
        if (live && drive_out_i) begin
            unique case (mode)
                LANE_DUAL: next_pins.io_oe_n = OE_DUAL;
                LANE_QUAD: next_pins.io_oe_n = OE_QUAD;
                default: next_pins.io_oe_n = OE_SINGLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cnt <= CNT_ZERO;
            shin <= '0;
            shout <= '0;
            overrun <= 1'b0;
            pins_o <= '{io: '0, io_oe_n: OE_NONE};
        end else begin
            cnt <= next_cnt;
            shin <= next_shin;
            shout <= next_shout;
            overrun <= next_overrun;
            pins_o <= next_pins;
        end
    end

    assign rx_overrun_o = overrun;

    sfpi_fifo #(
        .WIDTH(BYTE_BITS),
        .DEPTH(RX_DEPTH)
    ) u_rx_fifo (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(rx_push),
        .in_ready_o(rx_in_ready),
        .in_data_i(rx_byte),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    // ----------------------------------------
    // Protection and power status
    // ----------------------------------------
    logic next_allowed, next_ack, next_standby;

    always_comb begin
        next_ack = wreq_i.valid;
        next_allowed = write_allowed_o;
        if (wreq_i.valid) begin
            next_allowed = !(protect_on && sfpi_in_area(wreq_i.addr, protect_area_bits_i));
        end
        next_standby = (state == ST_DESEL || state == ST_POWERUP) && !op_busy_i;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            write_allowed_o <= 1'b0;
            write_ack_o <= 1'b0;
            standby_o <= 1'b0;
            selected_o <= 1'b0;
        end else begin
            write_allowed_o <= next_allowed;
            write_ack_o <= next_ack;
            standby_o <= next_standby;
            selected_o <= (next_state == ST_ACTIVE || next_state == ST_PAUSED);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_desel_float: assert property (@(posedge clk_i) disable iff (srst_i)
        (state == ST_DESEL) |=> (pins_o.io_oe_n == OE_NONE)) else $error("lane driven while deselected");
    chk_pause_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
        (state == ST_PAUSED) |=> (pins_o.io_oe_n == OE_NONE) && $stable(cnt)) else $error("activity during pause");
    chk_powerup_wait: assert property (@(posedge clk_i) disable iff (srst_i)
        (state == ST_POWERUP) && !cs_fall |=> (state == ST_POWERUP)) else $error("left power-up without select edge");
    chk_standby_busy: assert property (@(posedge clk_i) disable iff (srst_i)
        op_busy_i |=> !standby_o) else $error("standby while operation busy");
    chk_protect_block: assert property (@(posedge clk_i) disable iff (srst_i)
        wreq_i.valid && !four_lane_enable_i && !sync2.io[2] && sfpi_in_area(wreq_i.addr, protect_area_bits_i)
        |=> write_ack_o && !write_allowed_o) else $error("protected write allowed");
    chk_out_on_fall: assert property (@(posedge clk_i) disable iff (srst_i)
        !sclk_fall |=> $stable(pins_o.io)) else $error("output changed without falling edge");
    chk_byte_push: assert property (@(posedge clk_i) disable iff (srst_i)
        rx_push |-> (cnt_plus == CNT_BYTE) && sclk_rise && live) else $error("partial byte pushed");
    chk_sample_rise: assert property (@(posedge clk_i) disable iff (srst_i)
        live && !drive_out_i && sclk_rise && mode == LANE_SINGLE |=> shin[0] == $past(sync2.io[0]))
        else $error("lane 0 not sampled on rise");
    chk_single_lane: assert property (@(posedge clk_i) disable iff (srst_i)
        live && drive_out_i && mode == LANE_SINGLE |=> pins_o.io_oe_n == OE_SINGLE) else $error("bad single drive");
    chk_lane0_input: assert property (@(posedge clk_i) disable iff (srst_i)
        !drive_out_i |=> pins_o.io_oe_n[0]) else $error("lane 0 driven while receiving");
    chk_quad_lanes: assert property (@(posedge clk_i) disable iff (srst_i)
        !four_lane_enable_i |=> pins_o.io_oe_n[3:2] == 2'h3) else $error("upper lanes driven without quad");
    chk_quad_nopause: assert property (@(posedge clk_i) disable iff (srst_i)
        four_lane_enable_i && live && !sync2.cs_n |=> state == ST_ACTIVE) else $error("pause honoured in quad");
    chk_clock_stall: assert property (@(posedge clk_i) disable iff (srst_i)
        live && !sclk_rise && !sclk_fall && !sync2.cs_n && pause_n |=> $stable(cnt) && state == ST_ACTIVE)
        else $error("stopped clock disturbed transfer");

endmodule

// ==== sfpi_host_model.sv ====
// Behavioural host controller driving the flash pins in mode 3
`timescale 1ns/100ps
module sfpi_host_model
    import sfpi_pkg::*;
(
    input wire logic clk_i,
    input wire logic [3:0] io_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic [3:0] io_o,
    output logic [3:0] io_oe_n_o
);
    logic [1:0] ctl;

    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b0;
        io_o = 4'hC;
        io_oe_n_o = 4'h2;
        ctl = 2'h3;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Pause level on lane 3, protect level on lane 2
    task automatic set_ctl(input logic [1:0] c);
        @(posedge clk_i);
        ctl = c;
        io_o <= {c, io_o[1:0]};
        tick(4);
    endtask

    task automatic select();
        @(posedge clk_i);
        cs_n_o <= 1'b0;
        tick(8);
    endtask

    task automatic deselect();
        tick(4);
        cs_n_o <= 1'b1;
        io_oe_n_o <= 4'h2;
        tick(8);
    endtask

    // Clocks n bits, step lanes per edge, MSB first
    task automatic shift(input logic [7:0] tx, input int step, input logic rd, input int n, output logic [7:0] rx);
        logic [7:0] sh;
        sh = tx;
        rx = 8'h00;
        for (int i = 0; i < n; i += step) begin
            @(posedge clk_i);
            sclk_o <= 1'b0;
            io_oe_n_o <= rd ? (step == 4 ? 4'hF : step == 2 ? 4'h3 : 4'h2) : (step == 1 ? 4'h2 : 4'h0);
            io_o <= step == 4 ? sh[7:4] : step == 2 ? {ctl, sh[7:6]} : {ctl, 1'b0, sh[7]};
            sh = sh << step;
            tick(4);
            sclk_o <= 1'b1;
            tick(4);
            rx = step == 4 ? {rx[3:0], io_i} : step == 2 ? {rx[5:0], io_i[1:0]} : {rx[6:0], io_i[1]};
        end
    endtask
endmodule

// ==== tb_serial_flash_pin_interface.sv ====
// Self-checking bench for the serial flash pin interface
`timescale 1ns/100ps
module tb_serial_flash_pin_interface
    import sfpi_pkg::*;
;
    logic clk_i, srst_i, drive_out_i, four_lane_enable_i, op_busy_i, rx_ready_i, tx_valid_i, flt;
    logic write_allowed_o, write_ack_o, rx_valid_o, rx_overrun_o, tx_ready_o, selected_o, standby_o;
    logic h_sclk, h_cs_n;
    logic [2:0] protect_area_bits_i;
    logic [3:0] h_io, h_oe_n, io_w;
    logic [7:0] tx_data_i, rx_data_o, rx;
    sfpi_lane_t lane_mode_i;
    sfpi_wreq_t wreq_i;
    sfpi_pins_in_t pins_i;
    sfpi_pins_out_t pins_o;
    int miscompares, cmp_count;
    int tx_takes = 0;

    // Wire resolution; a lane nobody drives toggles
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            io_w[i] = !pins_o.io_oe_n[i] ? pins_o.io[i] : !h_oe_n[i] ? h_io[i] : flt;
        end
    end
    assign pins_i = '{sclk: h_sclk, cs_n: h_cs_n, io: io_w};

    sfpi_flash_pins uut (.clk_i(clk_i), .srst_i(srst_i), .pins_i(pins_i), .pins_o(pins_o),
        .lane_mode_i(lane_mode_i), .drive_out_i(drive_out_i), .four_lane_enable_i(four_lane_enable_i),
        .protect_area_bits_i(protect_area_bits_i), .op_busy_i(op_busy_i), .wreq_i(wreq_i),
        .write_allowed_o(write_allowed_o), .write_ack_o(write_ack_o), .rx_data_o(rx_data_o),
        .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_overrun_o(rx_overrun_o),
        .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o),
        .selected_o(selected_o), .standby_o(standby_o));

    sfpi_host_model host (.clk_i(clk_i), .io_i(io_w), .sclk_o(h_sclk), .cs_n_o(h_cs_n), .io_o(h_io),
        .io_oe_n_o(h_oe_n));

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    always @(posedge clk_i) flt <= ~flt;

    // Counts byte slots signalled on tx_ready_o, whether or not tx_valid_i is set
    always @(posedge clk_i) begin
        if (tx_ready_o === 1'b1) begin
            tx_takes <= tx_takes + 1;
        end
    end

    // ----------------------------------------
    // Compare and closing
    // ----------------------------------------
    task automatic cmp1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Takes one received byte through the valid/ready handshake
    task automatic pop(input logic [7:0] e);
        int n;
        n = 0;
        @(negedge clk_i);
        while (rx_valid_o !== 1'b1 && n < 300) begin
            @(negedge clk_i);
            n++;
        end
        cmp1("rx_valid", 1'b1, rx_valid_o);
        cmp8("rx_data", e, rx_data_o);
        @(posedge clk_i);
        rx_ready_i <= 1'b1;
        @(posedge clk_i);
        rx_ready_i <= 1'b0;
    endtask

    task automatic chk_wr(input logic [2:0] bp, input logic [23:0] a, input logic e);
        @(posedge clk_i);
        protect_area_bits_i <= bp;
        wreq_i <= '{valid: 1'b1, addr: a};
        @(posedge clk_i);
        wreq_i.valid <= 1'b0;
        @(negedge clk_i);
        cmp1("write_ack", 1'b1, write_ack_o);
        cmp1("write_allowed", e, write_allowed_o);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_powerup();
        host.shift(8'hFF, 1, 1'b0, 8, rx);
        @(negedge clk_i);
        cmp1("rx_valid", 1'b0, rx_valid_o);
        cmp1("selected", 1'b0, selected_o);
        cmp1("standby", 1'b1, standby_o);
        host.deselect();
    endtask

    task automatic t_write();
        host.select();
        @(negedge clk_i);
        cmp1("selected", 1'b1, selected_o);
        cmp1("standby", 1'b0, standby_o);
        host.shift(8'hA5, 1, 1'b0, 8, rx);
        host.shift(8'h3C, 1, 1'b0, 8, rx);
        pop(8'hA5);
        pop(8'h3C);
        host.shift(8'hB4, 1, 1'b0, 4, rx);
        host.set_ctl(2'h1);
        @(negedge clk_i);
        cmp1("selected_paused", 1'b1, selected_o);
        host.shift(8'hFF, 1, 1'b0, 4, rx);
        host.set_ctl(2'h3);
        host.tick(50);
        host.shift(8'h40, 1, 1'b0, 4, rx);
        pop(8'hB4);
        host.deselect();
    endtask

    task automatic t_read();
        @(posedge clk_i);
        drive_out_i <= 1'b1;
        tx_data_i <= 8'h96;
        tx_valid_i <= 1'b1;
        host.select();
        host.shift(8'h00, 1, 1'b1, 8, rx);
        cmp8("read_single", 8'h96, rx);
        @(negedge clk_i);
        cmp1("lane1_oe_n", 1'b0, pins_o.io_oe_n[1]);
        host.deselect();
        @(negedge clk_i);
        cmp8("oe_n_desel", {4'h0, OE_NONE}, {4'h0, pins_o.io_oe_n});
        @(posedge clk_i);
        lane_mode_i <= LANE_DUAL;
        tx_data_i <= 8'h69;
        host.select();
        host.shift(8'h00, 2, 1'b1, 8, rx);
        cmp8("read_dual", 8'h69, rx);
        host.deselect();
        @(posedge clk_i);
        tx_valid_i <= 1'b0;
        host.select();
        host.shift(8'h00, 2, 1'b1, 8, rx);
        cmp8("read_empty", 8'h00, rx);
        cmp8("tx_takes", 8'h03, 8'(tx_takes));
        host.deselect();
    endtask

    task automatic t_lanes();
        @(posedge clk_i);
        drive_out_i <= 1'b0;
        host.select();
        host.shift(8'hC3, 2, 1'b0, 8, rx);
        pop(8'hC3);
        host.deselect();
        @(posedge clk_i);
        four_lane_enable_i <= 1'b1;
        lane_mode_i <= LANE_QUAD;
        host.select();
        host.shift(8'h5A, 4, 1'b0, 8, rx);
        pop(8'h5A);
        host.set_ctl(2'h3);
        host.deselect();
        @(posedge clk_i);
        four_lane_enable_i <= 1'b0;
        host.select();
        host.shift(8'h81, 1, 1'b0, 8, rx);
        pop(8'h81);
        host.deselect();
        @(posedge clk_i);
        lane_mode_i <= LANE_SINGLE;
    endtask

    task automatic t_protect();
        host.set_ctl(2'h2);
        chk_wr(3'h1, 24'hFF0000, 1'b0);
        chk_wr(3'h1, 24'hFE0000, 1'b1);
        chk_wr(3'h3, 24'hFC0000, 1'b0);
        chk_wr(3'h3, 24'hFBFFFF, 1'b1);
        chk_wr(3'h7, 24'h000000, 1'b0);
        chk_wr(3'h0, 24'hFFFFFF, 1'b1);
        @(posedge clk_i);
        four_lane_enable_i <= 1'b1;
        chk_wr(3'h7, 24'h000000, 1'b1);
        @(posedge clk_i);
        four_lane_enable_i <= 1'b0;
        host.set_ctl(2'h3);
        chk_wr(3'h7, 24'h000000, 1'b1);
    endtask

    task automatic t_standby();
        @(posedge clk_i);
        op_busy_i <= 1'b1;
        host.tick(3);
        @(negedge clk_i);
        cmp1("standby_busy", 1'b0, standby_o);
        @(posedge clk_i);
        op_busy_i <= 1'b0;
        host.tick(3);
        @(negedge clk_i);
        cmp1("standby_idle", 1'b1, standby_o);
    endtask

    task automatic t_fifo();
        host.select();
        for (int i = 0; i < 17; i++) begin
            host.shift(8'h10 + 8'(i), 1, 1'b0, 8, rx);
        end
        @(negedge clk_i);
        cmp1("overrun", 1'b1, rx_overrun_o);
        for (int i = 0; i < 16; i++) begin
            pop(8'h10 + 8'(i));
        end
        @(negedge clk_i);
        cmp1("fifo_empty", 1'b0, rx_valid_o);
        host.deselect();
        @(negedge clk_i);
        cmp1("overrun_clear", 1'b0, rx_overrun_o);
    endtask

    initial begin
        miscompares = 0;
        cmp_count = 0;
        flt = 1'b0;
        srst_i = 1'b1;
        drive_out_i = 1'b0;
        four_lane_enable_i = 1'b0;
        op_busy_i = 1'b0;
        rx_ready_i = 1'b0;
        tx_valid_i = 1'b0;
        tx_data_i = 8'h00;
        protect_area_bits_i = 3'h0;
        lane_mode_i = LANE_SINGLE;
        wreq_i = '0;
        repeat (20) @(posedge clk_i);
        srst_i <= 1'b0;
        t_powerup();
        t_write();
        t_read();
        t_lanes();
        t_protect();
        t_standby();
        t_fifo();
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        miscompares++;
        report_and_stop();
    end
endmodule
